// *** hw/fsec_pkg.sv ***
// constants and types of the nvm security gate and program/erase clock divider
// assumes a 10 MHz bus clock and a 16-bit cpu address space
package fsec_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 10000000;
	localparam int unsigned PE_CLK_MIN_KHZ = 150;
	localparam int unsigned PE_CLK_MAX_KHZ = 200;
	// fewest bus cycles in one program/erase pulse at the top allowed rate
	localparam int unsigned PE_PULSE_MIN_CYC = CLK_HZ / (PE_CLK_MAX_KHZ * 1000);
	localparam logic [2:0] PRESCALE_LAST = 3'h7;

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_DIVIDER = 8'h00;
	localparam logic [7:0] OFF_CONFIG = 8'h04;
	localparam logic [7:0] OFF_OPTION = 8'h08;
	localparam logic [7:0] OFF_PROTECT = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int unsigned DIV_LOADED_BIT = 7;
	localparam int unsigned DIV_PRESCALE_BIT = 6;
	localparam int unsigned CFG_KEY_ACCESS_BIT = 5;
	localparam int unsigned OPT_KEY_ENABLE_BIT = 7;
	localparam int unsigned STAT_SECURED_BIT = 0;
	localparam int unsigned STAT_ACC_ERR_BIT = 1;
	localparam logic [7:0] OPT_IMPL_MASK = 8'hC3;
	localparam logic [1:0] SEC_UNSECURED = 2'h2;
	localparam logic [6:0] DIVIDER_RESET = 7'h00;
	localparam logic [2:0] CONFIG_RESET = 3'h0;
	localparam logic [7:0] INVALID_READ = 8'hFF;

	// ----------------------------------------------------------------
	// memory map of the secure resources
	// ----------------------------------------------------------------
	localparam logic [15:0] FLASH_BASE = 16'hC000;
	localparam logic [15:0] RAM_BASE = 16'h0080;
	localparam logic [15:0] RAM_LAST = 16'h047F;
	localparam logic [15:0] VECTOR_BLOCK = 16'hFE00;
	localparam logic [15:0] KEY_BASE = 16'hFFB0;
	localparam logic [15:0] OPTION_ADDR = 16'hFFBF;
	localparam logic [8:0] PROT_LOW_ONES = 9'h1FF;
	localparam logic [3:0] KEY_BYTES = 4'h8;

	// origin of a memory access
	typedef enum logic [1:0] {
		SRC_SECURE_FLASH = 2'b00,
		SRC_RAM = 2'b01,
		SRC_UNSECURED = 2'b10,
		SRC_DEBUG = 2'b11
	} fsec_src_e;
endpackage

// *** hw/fsec_div_if.sv ***
// carrier between the security core and the program/erase clock divider
// assumes both ends run on the bus clock
`timescale 1ns/100ps
`default_nettype none
interface fsec_div_if;
	logic en;
	logic prescale;
	logic [5:0] divisor;
	logic tick;
	modport ctl (output en, output prescale, output divisor, input tick);
	modport div (input en, input prescale, input divisor, output tick);
endinterface
`default_nettype wire

// *** hw/fsec_pe_clkdiv.sv ***
// program/erase clock divider: one-cycle tick per internal pe clock period
// assumes settings stay stable while en is high
`timescale 1ns/100ps
`default_nettype none
module fsec_pe_clkdiv (
	input wire logic aclk,
	input wire logic aresetn,
	fsec_div_if.div dif
);
	logic [2:0] pre_cnt_ff;
	logic [2:0] nxt_pre_cnt;
	logic [5:0] div_cnt_ff;
	logic [5:0] nxt_div_cnt;
	logic tick_ff;
	logic nxt_tick;
	logic pre_tick;

	// ----------------------------------------------------------------
	// counters
	// ----------------------------------------------------------------
	always_comb begin
		nxt_pre_cnt = pre_cnt_ff;
		nxt_div_cnt = div_cnt_ff;
		nxt_tick = 1'b0;
		pre_tick = 1'b0;
		if (!dif.en) begin
			nxt_pre_cnt = 3'h0;
			nxt_div_cnt = 6'h00;
		end else begin
			// bus clock, or bus clock over eight
			if (!dif.prescale || pre_cnt_ff == fsec_pkg::PRESCALE_LAST) begin
				pre_tick = 1'b1;
			end
			nxt_pre_cnt = dif.prescale ? pre_cnt_ff + 3'h1 : 3'h0;
			if (pre_tick) begin
				// divisor plus one input periods per pulse
				if (div_cnt_ff >= dif.divisor) begin
					nxt_div_cnt = 6'h00;
					nxt_tick = 1'b1;
				end else begin
					nxt_div_cnt = div_cnt_ff + 6'h01;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_cnt_ff <= 3'h0;
			div_cnt_ff <= 6'h00;
			tick_ff <= 1'b0;
		end else begin
			pre_cnt_ff <= nxt_pre_cnt;
			div_cnt_ff <= nxt_div_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign dif.tick = tick_ff;
endmodule
`default_nettype wire

// *** hw/fsec_top.sv ***
// nvm security gate, backdoor key check and program/erase clock divider
// assumes array read data arrives combinationally with mem_addr, same clock
//
// Overview of operation
// - while secured, untrusted or debug access to flash/ram: writes dropped, reads zero
// - only security code 1:0 means unsecured; the other three codes secure
// - every reset copies bits 7:6 and 1:0 of the nonvolatile option byte into the working option register
// - secured: debug module stays off; background mode only from pin low at reset
// - key enable at 0 disables the backdoor key; only full erase unlocks
// - with key access set, key location writes are compare values, not commands
// - clearing key access after eight matching bytes unsecures until next reset
// - key compare writes are accepted only from code running in ram
// - working protection register is writable only by debug commands
// - blank check finding the whole array erased unsecures until next reset
// - key and option bytes share the vector 512-byte block and its protection
// - divider bit 7 is read-only status; bits 6:0 written once after reset
// - reset clears divider-loaded; first write sets it; clear flag blocks program/erase
// - prescale 0 feeds the bus clock, 1 feeds the bus clock over eight
// - program/erase clock is the divider input over divisor plus one
// - each timing pulse is one pe clock cycle; operations end on a pulse boundary, but start mid-pulse on the free-running divider
// - array write before divider is written sets access error, starts nothing
// - while key access is set, array reads that are not blocked return invalid data
`timescale 1ns/100ps
`default_nettype none
module fsec_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic dbg_master,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [7:0] nonvolatile_option_byte,
	input wire logic [7:0] nonvolatile_protect_byte,
	input wire logic [63:0] backdoor_key_locations,
	input wire logic background_mode_pin,
	input wire logic dbg_enable_req,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [1:0] mem_src,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic [7:0] arr_rdata,
	input wire logic blank_check_done,
	input wire logic blank_check_erased,
	input wire logic op_start,
	input wire logic [15:0] op_pulses,
	output logic mem_ack,
	output logic [7:0] mem_rdata,
	output logic arr_wr,
	output logic [15:0] arr_addr,
	output logic [7:0] arr_wdata,
	output logic pe_tick,
	output logic op_busy,
	output logic secured,
	output logic dbg_module_en,
	output logic bg_mode_active,
	output logic access_error
);
	// ----------------------------------------------------------------
	// register bus slave
	// ----------------------------------------------------------------
	logic awready_ff, nxt_awready, wready_ff, nxt_wready, bvalid_ff, nxt_bvalid;
	logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold, aw_dbg_ff, nxt_aw_dbg;
	logic [7:0] aw_addr_ff, nxt_aw_addr, w_byte_ff, nxt_w_byte;
	logic w_strb0_ff, nxt_w_strb0;
	logic [1:0] bresp_ff, nxt_bresp;
	logic arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
	logic [7:0] rbyte_ff, nxt_rbyte, rd_sel;
	logic [1:0] rresp_ff, nxt_rresp;
	logic do_wr, wr_en0, rd_hit, wr_hit;
	logic [7:0] wr_addr, rd_addr;

	assign wr_addr = {aw_addr_ff[7:2], 2'h0};
	assign rd_addr = {araddr[7:2], 2'h0};
	assign do_wr = aw_hold_ff && w_hold_ff && !bvalid_ff;
	assign wr_en0 = do_wr && w_strb0_ff;
	assign wr_hit = wr_addr <= fsec_pkg::OFF_STATUS;
	assign rd_hit = rd_addr <= fsec_pkg::OFF_STATUS;

	always_comb begin
		nxt_aw_hold = aw_hold_ff;
		nxt_aw_addr = aw_addr_ff;
		nxt_aw_dbg = aw_dbg_ff;
		nxt_w_hold = w_hold_ff;
		nxt_w_byte = w_byte_ff;
		nxt_w_strb0 = w_strb0_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_arready = arready_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rbyte = rbyte_ff;
		nxt_rresp = rresp_ff;
		if (awvalid && awready_ff) begin
			nxt_aw_hold = 1'b1;
			nxt_aw_addr = awaddr;
			nxt_aw_dbg = dbg_master;
		end
		if (wvalid && wready_ff) begin
			nxt_w_hold = 1'b1;
			nxt_w_byte = wdata[7:0];
			nxt_w_strb0 = wstrb[0];
		end
		if (do_wr) begin
			nxt_aw_hold = 1'b0;
			nxt_w_hold = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = wr_hit ? fsec_pkg::RESP_OKAY : fsec_pkg::RESP_DECERR;
		end else if (bvalid_ff && bready) begin
			nxt_bvalid = 1'b0;
		end
		nxt_awready = !nxt_aw_hold && !nxt_bvalid;
		nxt_wready = !nxt_w_hold && !nxt_bvalid;
		if (arvalid && arready_ff) begin
			nxt_arready = 1'b0;
			nxt_rvalid = 1'b1;
			nxt_rbyte = rd_sel;
			nxt_rresp = rd_hit ? fsec_pkg::RESP_OKAY : fsec_pkg::RESP_DECERR;
		end else if (rvalid_ff && rready) begin
			nxt_rvalid = 1'b0;
			nxt_arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			bvalid_ff <= 1'b0;
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			aw_dbg_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_byte_ff <= 8'h00;
			w_strb0_ff <= 1'b0;
			bresp_ff <= fsec_pkg::RESP_OKAY;
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rbyte_ff <= 8'h00;
			rresp_ff <= fsec_pkg::RESP_OKAY;
		end else begin
			awready_ff <= nxt_awready;
			wready_ff <= nxt_wready;
			bvalid_ff <= nxt_bvalid;
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff <= nxt_w_hold;
			aw_dbg_ff <= nxt_aw_dbg;
			aw_addr_ff <= nxt_aw_addr;
			w_byte_ff <= nxt_w_byte;
			w_strb0_ff <= nxt_w_strb0;
			bresp_ff <= nxt_bresp;
			arready_ff <= nxt_arready;
			rvalid_ff <= nxt_rvalid;
			rbyte_ff <= nxt_rbyte;
			rresp_ff <= nxt_rresp;
		end
	end

	// ----------------------------------------------------------------
	// security core, key check, memory gate
	// ----------------------------------------------------------------
	logic [7:0] opt_ff, prot_ff, nxt_prot;
	logic [6:0] div_ff, nxt_div;
	logic div_loaded_ff, nxt_div_loaded, unsec_ff, nxt_unsec, secured_ff, nxt_secured;
	logic [2:0] cfg_ff, nxt_cfg;
	logic acc_err_ff, nxt_acc_err, dbg_en_ff, nxt_dbg_en;
	logic [7:0] key_buf_ff [8];
	logic [7:0] nxt_key_buf [8];
	logic [3:0] key_idx_ff, nxt_key_idx;
	logic key_bad_ff, nxt_key_bad, key_match;
	logic mem_ack_ff, arr_wr_ff;
	logic [7:0] mem_rdata_ff, nxt_mem_rdata, arr_wdata_ff;
	logic [15:0] arr_addr_ff;
	logic nxt_arr_wr;
	logic key_access, key_en, in_flash, in_ram, in_key, untrusted, blocked, prot_hit;
	logic key_wr, key_clr, arr_write;
	logic [1:0] eff_sec;
	logic bkgd_s1_ff, bkgd_s2_ff, rst_seen_ff, bg_ff;

	assign key_access = cfg_ff[fsec_pkg::CFG_KEY_ACCESS_BIT - 5];
	assign key_en = opt_ff[fsec_pkg::OPT_KEY_ENABLE_BIT];
	assign eff_sec = unsec_ff ? fsec_pkg::SEC_UNSECURED : opt_ff[1:0];
	assign in_flash = mem_addr >= fsec_pkg::FLASH_BASE;
	assign in_ram = mem_addr >= fsec_pkg::RAM_BASE && mem_addr <= fsec_pkg::RAM_LAST;
	assign in_key = mem_addr[15:3] == fsec_pkg::KEY_BASE[15:3];
	assign untrusted = mem_src == fsec_pkg::SRC_UNSECURED || mem_src == fsec_pkg::SRC_DEBUG;
	assign blocked = secured_ff && untrusted && (in_flash || in_ram);
	// key and option bytes sit above the vector block boundary, so any protection covers them
	assign prot_hit = !prot_ff[0] && mem_addr > {prot_ff[7:1], fsec_pkg::PROT_LOW_ONES};
	// only ram code may enter the key, debug commands cannot
	assign key_wr = mem_req && mem_we && !blocked && in_key && key_access && key_en
		&& mem_src == fsec_pkg::SRC_RAM;
	assign arr_write = mem_req && mem_we && !blocked && in_flash && !(key_access && in_key);
	assign key_clr = wr_en0 && wr_addr == fsec_pkg::OFF_CONFIG && key_access
		&& !w_byte_ff[fsec_pkg::CFG_KEY_ACCESS_BIT];

	always_comb begin
		key_match = key_idx_ff == fsec_pkg::KEY_BYTES && !key_bad_ff;
		for (int i = 0; i < 8; i++) begin
			if (key_buf_ff[i] != backdoor_key_locations[i*8 +: 8]) begin
				key_match = 1'b0;
			end
		end
	end

	always_comb begin
		case (rd_addr)
			fsec_pkg::OFF_DIVIDER: rd_sel = {div_loaded_ff, div_ff};
			fsec_pkg::OFF_CONFIG: rd_sel = {cfg_ff, 5'h00};
			fsec_pkg::OFF_OPTION: rd_sel = {opt_ff[7:2], eff_sec};
			fsec_pkg::OFF_PROTECT: rd_sel = prot_ff;
			fsec_pkg::OFF_STATUS: rd_sel = {6'h00, acc_err_ff, secured_ff};
			default: rd_sel = 8'h00;
		endcase
	end

	always_comb begin
		nxt_prot = prot_ff;
		nxt_div = div_ff;
		nxt_div_loaded = div_loaded_ff;
		nxt_cfg = cfg_ff;
		nxt_unsec = unsec_ff;
		nxt_acc_err = acc_err_ff;
		nxt_key_buf = key_buf_ff;
		nxt_key_idx = key_idx_ff;
		nxt_key_bad = key_bad_ff;
		nxt_arr_wr = 1'b0;
		if (wr_en0 && wr_addr == fsec_pkg::OFF_DIVIDER && !div_loaded_ff) begin
			nxt_div = w_byte_ff[6:0];
			nxt_div_loaded = 1'b1;
		end
		if (wr_en0 && wr_addr == fsec_pkg::OFF_PROTECT && aw_dbg_ff) begin
			nxt_prot = w_byte_ff;
		end
		if (wr_en0 && wr_addr == fsec_pkg::OFF_CONFIG) begin
			nxt_cfg = w_byte_ff[7:5];
			if (!key_access && w_byte_ff[fsec_pkg::CFG_KEY_ACCESS_BIT]) begin
				nxt_key_idx = 4'h0;
				nxt_key_bad = 1'b0;
			end
		end
		if (wr_en0 && wr_addr == fsec_pkg::OFF_STATUS && w_byte_ff[fsec_pkg::STAT_ACC_ERR_BIT]) begin
			nxt_acc_err = 1'b0;
		end
		// a mismatch falls through and leaves the state as it was
		if (key_clr && key_match) begin
			nxt_unsec = 1'b1;
		end
		if (blank_check_done && blank_check_erased) begin
			nxt_unsec = 1'b1;
		end
		if (key_wr) begin
			// out of order bytes spoil the attempt rather than shift it
			if (key_idx_ff < fsec_pkg::KEY_BYTES && mem_addr[2:0] == key_idx_ff[2:0]) begin
				nxt_key_buf[key_idx_ff[2:0]] = mem_wdata;
				nxt_key_idx = key_idx_ff + 4'h1;
			end else begin
				nxt_key_bad = 1'b1;
			end
		end
		// set after clear so a fresh error is never lost
		if (arr_write) begin
			if (!div_loaded_ff || prot_hit) begin
				nxt_acc_err = 1'b1;
			end else begin
				nxt_arr_wr = 1'b1;
			end
		end
		nxt_secured = (nxt_unsec ? fsec_pkg::SEC_UNSECURED : opt_ff[1:0]) != fsec_pkg::SEC_UNSECURED;
		nxt_dbg_en = dbg_enable_req && !nxt_secured;
		if (blocked) begin
			nxt_mem_rdata = 8'h00;
		end else if (key_access && in_flash) begin
			nxt_mem_rdata = fsec_pkg::INVALID_READ;
		end else begin
			nxt_mem_rdata = arr_rdata;
		end
	end

	always_ff @(posedge aclk) begin
		bkgd_s1_ff <= background_mode_pin;
		bkgd_s2_ff <= bkgd_s1_ff;
		if (!aresetn) begin
			opt_ff <= nonvolatile_option_byte & fsec_pkg::OPT_IMPL_MASK;
			prot_ff <= nonvolatile_protect_byte;
			div_ff <= fsec_pkg::DIVIDER_RESET;
			div_loaded_ff <= 1'b0;
			cfg_ff <= fsec_pkg::CONFIG_RESET;
			unsec_ff <= 1'b0;
			secured_ff <= 1'b1;
			acc_err_ff <= 1'b0;
			dbg_en_ff <= 1'b0;
			key_idx_ff <= 4'h0;
			key_bad_ff <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				key_buf_ff[i] <= 8'h00;
			end
			mem_ack_ff <= 1'b0;
			mem_rdata_ff <= 8'h00;
			arr_wr_ff <= 1'b0;
			arr_addr_ff <= 16'h0000;
			arr_wdata_ff <= 8'h00;
			rst_seen_ff <= 1'b0;
			bg_ff <= 1'b0;
		end else begin
			prot_ff <= nxt_prot;
			div_ff <= nxt_div;
			div_loaded_ff <= nxt_div_loaded;
			cfg_ff <= nxt_cfg;
			unsec_ff <= nxt_unsec;
			secured_ff <= nxt_secured;
			acc_err_ff <= nxt_acc_err;
			dbg_en_ff <= nxt_dbg_en;
			key_idx_ff <= nxt_key_idx;
			key_bad_ff <= nxt_key_bad;
			key_buf_ff <= nxt_key_buf;
			mem_ack_ff <= mem_req;
			mem_rdata_ff <= nxt_mem_rdata;
			arr_wr_ff <= nxt_arr_wr;
			arr_addr_ff <= mem_addr;
			arr_wdata_ff <= mem_wdata;
			rst_seen_ff <= 1'b1;
			// pin level held just before the reset release decides background entry
			if (!rst_seen_ff) begin
				bg_ff <= !bkgd_s2_ff;
			end
		end
	end

	// ----------------------------------------------------------------
	// divider and operation timer
	// ----------------------------------------------------------------
	fsec_div_if dif ();
	assign dif.en = div_loaded_ff;
	assign dif.prescale = div_ff[fsec_pkg::DIV_PRESCALE_BIT];
	assign dif.divisor = div_ff[5:0];

	fsec_pe_clkdiv u_clkdiv (
		.aclk(aclk),
		.aresetn(aresetn),
		.dif(dif)
	);

	logic busy_ff, nxt_busy;
	logic [15:0] pulse_cnt_ff, nxt_pulse_cnt;

	always_comb begin
		nxt_busy = busy_ff;
		nxt_pulse_cnt = pulse_cnt_ff;
		if (!busy_ff && op_start && div_loaded_ff && op_pulses != 16'h0000) begin
			nxt_busy = 1'b1;
			nxt_pulse_cnt = op_pulses;
		end else if (busy_ff && dif.tick) begin
			// operations end only on a pulse boundary
			nxt_pulse_cnt = pulse_cnt_ff - 16'h0001;
			nxt_busy = pulse_cnt_ff != 16'h0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_ff <= 1'b0;
			pulse_cnt_ff <= 16'h0000;
		end else begin
			busy_ff <= nxt_busy;
			pulse_cnt_ff <= nxt_pulse_cnt;
		end
	end

	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rdata = {24'h000000, rbyte_ff};
	assign rresp = rresp_ff;
	assign mem_ack = mem_ack_ff;
	assign mem_rdata = mem_rdata_ff;
	assign arr_wr = arr_wr_ff;
	assign arr_addr = arr_addr_ff;
	assign arr_wdata = arr_wdata_ff;
	assign pe_tick = dif.tick;
	assign op_busy = busy_ff;
	assign secured = secured_ff;
	assign dbg_module_en = dbg_en_ff;
	assign bg_mode_active = bg_ff;
	assign access_error = acc_err_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [9:0] gap_ff;
	logic gap_seen_ff;
	always_ff @(posedge aclk) begin
		gap_ff <= (!aresetn || dif.tick || !div_loaded_ff) ? 10'h001 : gap_ff + 10'h001;
		gap_seen_ff <= aresetn && div_loaded_ff && (gap_seen_ff || dif.tick);
	end

	chk_block_read: assert property (mem_req && !mem_we && blocked |=> mem_ack_ff && mem_rdata_ff == 8'h00)
		else $error("blocked read did not return zero");
	chk_block_write: assert property (mem_req && mem_we && blocked |=> !arr_wr_ff)
		else $error("blocked write reached the array");
	chk_sec_code: assert property ($past(aresetn) |-> secured_ff == (eff_sec != fsec_pkg::SEC_UNSECURED))
		else $error("security state does not follow the code");
	chk_dbg_off: assert property (secured_ff |-> !dbg_en_ff)
		else $error("debug module enabled while secured");
	chk_key_nocmd: assert property (mem_req && mem_we && key_access && in_key |=> !arr_wr_ff)
		else $error("key write started a command");
	chk_key_noen: assert property (!key_en && !(blank_check_done && blank_check_erased) && !unsec_ff |=> !unsec_ff)
		else $error("unlocked with backdoor key disabled");
	chk_key_miss: assert property (key_clr && !key_match && !blank_check_done |=> $stable(unsec_ff))
		else $error("mismatching key changed security");
	chk_blank_rel: assert property (blank_check_done && blank_check_erased |=> !secured_ff ##1 !secured_ff)
		else $error("blank check did not release security");
	chk_div_once: assert property (div_loaded_ff |=> $stable(div_ff) && div_loaded_ff)
		else $error("divider changed after first write");
	chk_nodiv_err: assert property (arr_write && !div_loaded_ff |=> acc_err_ff && !arr_wr_ff)
		else $error("array write before divider load not flagged");
	chk_prot_app: assert property (wr_en0 && wr_addr == 8'h0C && !aw_dbg_ff |=> $stable(prot_ff))
		else $error("application changed protection");
	chk_key_access_bit_rd: assert property (mem_req && !mem_we && key_access && in_flash && !blocked |=> mem_rdata_ff == 8'hFF)
		else $error("array read valid during key access");
	chk_tick_gap: assert property (dif.tick && gap_seen_ff |-> 11'(gap_ff) ==
		(11'(div_ff[5:0]) + 11'h001) * (div_ff[6] ? 11'h008 : 11'h001))
		else $error("program/erase pulse period wrong");

	cov_key_unlock: cover property (key_clr && key_match);
	cov_blank_rel: cover property (blank_check_done && blank_check_erased && secured_ff);
	cov_block_rd: cover property (mem_req && !mem_we && blocked);
	cov_op_done: cover property (busy_ff ##1 !busy_ff);
endmodule
`default_nettype wire

// *** dv/fsec_array_model.sv ***
// far-side array and ram model: read data for the address on the memory port
// assumes the gate samples arr_rdata in the same cycle as the request
`timescale 1ns/100ps
`default_nettype none
module fsec_array_model (
	input wire logic [15:0] mem_addr,
	output logic [7:0] arr_rdata
);
	// never zero, so a blocked read stands out
	assign arr_rdata = mem_addr[7:0] | 8'h01;
endmodule
`default_nettype wire

// *** dv/fsec_top_test.sv ***
// self-checking bench of the security gate and pe clock divider
// assumes the array model answers reads at once
`timescale 1ns/100ps
`default_nettype none
module fsec_top_test;
	logic aclk, aresetn, awvalid, awready, dbg_master, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, background_mode_pin, dbg_enable_req, mem_req, mem_we;
	logic blank_check_done, blank_check_erased, op_start, mem_ack, arr_wr, pe_tick, op_busy;
	logic secured, dbg_module_en, bg_mode_active, access_error;
	logic [7:0] awaddr, araddr, nonvolatile_option_byte, nonvolatile_protect_byte;
	logic [7:0] arr_rdata, mem_wdata, mem_rdata, arr_wdata;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, mem_src;
	logic [15:0] mem_addr, op_pulses, arr_addr;
	logic [63:0] backdoor_key_locations;
	int n_fail = 0;
	int n_tests = 0;
	logic [1:0] br;
	fsec_top dut_u (.*);
	fsec_array_model arr_u (.mem_addr(mem_addr), .arr_rdata(arr_rdata));
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task final_report;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// a wait that ran out ends the run
	task lim(input int i);
		if (i >= 200) begin
			n_fail++;
			final_report;
		end
	endtask
	// each channel is released at the edge that takes it; answers are taken at their handshake edge
	task wr(input logic [7:0] a, input logic [7:0] d, input logic dm);
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		dbg_master <= dm;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		lim(i);
		br = bresp;
		bready <= 1'b0;
		@(negedge aclk);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		lim(i);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(negedge aclk);
	endtask
	// mid-run reset with a new option byte and the mode pin held low
	task rst(input logic [7:0] o);
		@(posedge aclk);
		aresetn <= 1'b0;
		nonvolatile_option_byte <= o;
		background_mode_pin <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		@(negedge aclk);
	endtask
	task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(nm, d, e);
	endtask
	// one request, answer sampled mid-cycle; leaves an idle cycle after it
	task mem(input logic [1:0] s, input logic we, input logic [15:0] a, input logic [7:0] d);
		@(posedge aclk);
		mem_req <= 1'b1;
		mem_we <= we;
		mem_src <= s;
		mem_addr <= a;
		mem_wdata <= d;
		@(posedge aclk);
		mem_req <= 1'b0;
		@(negedge aclk);
	endtask
	task key(input logic [1:0] s, input logic [7:0] bad);
		wr(fsec_pkg::OFF_CONFIG, 8'h20, 1'b0);
		for (int i = 0; i < 8; i++) begin
			mem(s, 1'b1, fsec_pkg::KEY_BASE + 16'(i), backdoor_key_locations[8*i+:8] ^ (i == 7 ? bad : 8'h00));
			chk("key_fwd", arr_wr, 1'b0);
		end
		wr(fsec_pkg::OFF_CONFIG, 8'h00, 1'b0);
		@(negedge aclk);
	endtask
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		int i;
		logic [31:0] d;
		logic [1:0] r;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, dbg_master, mem_req, mem_we} = '0;
		{blank_check_done, blank_check_erased, op_start} = '0;
		{awaddr, araddr, wdata, mem_src, mem_addr, mem_wdata, op_pulses} = '0;
		wstrb = 4'h1;
		background_mode_pin = 1'b1;
		dbg_enable_req = 1'b1;
		nonvolatile_option_byte = 8'h83;
		nonvolatile_protect_byte = 8'hFF;
		backdoor_key_locations = 64'h0123456789ABCDEF;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rc("divider", fsec_pkg::OFF_DIVIDER, 32'h00);
		rc("option", fsec_pkg::OFF_OPTION, 32'h83);
		chk("secured", {secured, dbg_module_en, bg_mode_active}, 3'b100);
		mem(2'h3, 1'b0, fsec_pkg::RAM_BASE, 8'h00);
		chk("dbg_read", {mem_ack, mem_rdata}, 9'h100);
		mem(2'h2, 1'b1, fsec_pkg::FLASH_BASE, 8'h12);
		chk("unsec_write", arr_wr, 1'b0);
		mem(2'h0, 1'b1, fsec_pkg::FLASH_BASE, 8'h12);
		chk("early_write", {arr_wr, access_error}, 2'b01);
		wr(fsec_pkg::OFF_STATUS, 8'h02, 1'b0);
		rc("status", fsec_pkg::OFF_STATUS, 32'h01);
		$display("test reset_and_gate done");
		wr(fsec_pkg::OFF_DIVIDER, 8'h46, 1'b0);
		wr(fsec_pkg::OFF_DIVIDER, 8'h05, 1'b0);
		rc("divider", fsec_pkg::OFF_DIVIDER, 32'hC6);
		// the first tick after loading may be early, so time the second gap
		repeat (2) begin
			for (i = 0; i < 200; i++) begin
				@(negedge aclk);
				if (pe_tick) break;
			end
			lim(i);
		end
		for (i = 1; i < 200; i++) begin
			@(negedge aclk);
			if (pe_tick) break;
		end
		chk("tick_period", i, 32'h38);
		mem(2'h0, 1'b1, fsec_pkg::FLASH_BASE, 8'h34);
		chk("loaded_write", {arr_wr, arr_addr, arr_wdata}, {1'b1, fsec_pkg::FLASH_BASE, 8'h34});
		@(posedge aclk);
		op_pulses <= 16'h0002;
		op_start <= 1'b1;
		@(posedge aclk);
		op_start <= 1'b0;
		d = '0;
		for (i = 0; i < 200; i++) begin
			@(negedge aclk);
			if (!op_busy) break;
			d += pe_tick;
		end
		lim(i);
		chk("op_pulses", d, 32'h2);
		$display("test divider done");
		wr(fsec_pkg::OFF_PROTECT, 8'h00, 1'b0);
		rc("prot_app", fsec_pkg::OFF_PROTECT, 32'hFF);
		wr(fsec_pkg::OFF_PROTECT, 8'hDE, 1'b1);
		rc("prot_dbg", fsec_pkg::OFF_PROTECT, 32'hDE);
		mem(2'h0, 1'b1, fsec_pkg::VECTOR_BLOCK, 8'h00);
		chk("prot_hit", {arr_wr, access_error}, 2'b01);
		rd(8'h14, d, r);
		chk("unmapped", r, fsec_pkg::RESP_DECERR);
		wr(8'h14, 8'h00, 1'b0);
		chk("unmapped_wr", br, fsec_pkg::RESP_DECERR);
		$display("test protect done");
		wr(fsec_pkg::OFF_CONFIG, 8'h20, 1'b0);
		mem(2'h0, 1'b0, fsec_pkg::FLASH_BASE, 8'h00);
		chk("key_access_bit_read", mem_rdata, fsec_pkg::INVALID_READ);
		key(2'h3, 8'h00);
		chk("dbg_key", secured, 1'b1);
		key(2'h1, 8'h01);
		chk("bad_key", secured, 1'b1);
		key(2'h1, 8'h00);
		chk("good_key", {secured, dbg_module_en}, 2'b01);
		rc("option_open", fsec_pkg::OFF_OPTION, 32'h82);
		mem(2'h3, 1'b0, fsec_pkg::RAM_BASE, 8'h00);
		chk("open_read", mem_rdata, 8'h81);
		$display("test key done");
		rst(8'h03);
		chk("reset_again", {secured, bg_mode_active, dbg_module_en}, 3'b110);
		key(2'h1, 8'h00);
		chk("key_disabled", secured, 1'b1);
		@(posedge aclk);
		{blank_check_done, blank_check_erased} <= 2'b11;
		@(posedge aclk);
		blank_check_done <= 1'b0;
		@(negedge aclk);
		chk("blank_open", secured, 1'b0);
		rst(8'h82);
		chk("dev_open", secured, 1'b0);
		$display("test reset done");
		final_report;
	end
endmodule
`default_nettype wire
